// file: hdl/adcc_pkg.sv
// Constants, encodings and types for the converter control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one 20 MHz clock.
package adcc_pkg;
  // ----------------------------------------------------------------
  // Bus and widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W = 10;
  localparam int unsigned CHS_W = 5;
  localparam int unsigned CS_W = 3;
  localparam int unsigned DIV_W = 6;
  localparam int unsigned BIT_W = 4;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_RES_HI = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_RES_LO = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_ENABLES = 5'h14;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ENABLE_BIT = 0;
  localparam int unsigned GO_BIT = 1;
  localparam int unsigned CHS_LSB = 2;
  localparam int unsigned REF_BIT = 0;
  localparam int unsigned CS_LSB = 4;
  localparam int unsigned DONE_FLAG_BIT = 6;
  localparam int unsigned HI_LSB = 8;
  localparam logic [CHS_W-1:0] CHS_RESET = 5'h00;
  localparam logic [CS_W-1:0] CS_RESET = 3'h0;
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;
  // ----------------------------------------------------------------
  // Conversion clock codes and divider terminal counts
  // ----------------------------------------------------------------
  localparam logic [CS_W-1:0] CS_DIV8 = 3'h1;
  localparam logic [CS_W-1:0] CS_DIV32 = 3'h2;
  localparam logic [CS_W-1:0] CS_DIV16 = 3'h5;
  localparam logic [CS_W-1:0] CS_DIV64 = 3'h6;
  localparam logic [1:0] CS_RC_LOW = 2'h3;
  localparam logic [DIV_W-1:0] LAST_DIV8 = 6'h07;
  localparam logic [DIV_W-1:0] LAST_DIV16 = 6'h0f;
  localparam logic [DIV_W-1:0] LAST_DIV32 = 6'h1f;
  localparam logic [DIV_W-1:0] LAST_DIV64 = 6'h3f;
  localparam logic [DIV_W-1:0] LAST_RC = 6'h0f;
  localparam logic [DIV_W-1:0] DIV_ZERO = 6'h00;
  localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;
  // ----------------------------------------------------------------
  // Successive approximation
  // ----------------------------------------------------------------
  localparam logic [RES_W-1:0] TRIAL_MSB = 10'h200;
  localparam logic [BIT_W-1:0] TOP_BIT = 4'h9;
  localparam logic [BIT_W-1:0] BIT_ZERO = 4'h0;
  localparam logic [BIT_W-1:0] BIT_ONE = 4'h1;
  localparam logic [BIT_W-1:0] TRIALS = 4'ha;
  typedef enum logic {SAR_IDLE, SAR_CONVERT} adcc_sar_state_type;
endpackage

// file: hdl/adcc_clkdiv.sv
// Conversion clock divider: a one-cycle tick at the selected rate.
// Assumes the system clock is also the internal oscillator.
`timescale 1ns/1ns
module adcc_clkdiv (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic [adcc_pkg::CS_W-1:0] select,
  output logic tick
);
  logic [adcc_pkg::DIV_W-1:0] count_q;
  logic [adcc_pkg::DIV_W-1:0] last;
  logic valid;

  always_comb begin
    valid = 1'b1;
    last = adcc_pkg::DIV_ZERO;
    if (select[1:0] == adcc_pkg::CS_RC_LOW) begin
      last = adcc_pkg::LAST_RC;
    end else if (select == adcc_pkg::CS_DIV8) begin
      last = adcc_pkg::LAST_DIV8;
    end else if (select == adcc_pkg::CS_DIV16) begin
      last = adcc_pkg::LAST_DIV16;
    end else if (select == adcc_pkg::CS_DIV32) begin
      last = adcc_pkg::LAST_DIV32;
    end else if (select == adcc_pkg::CS_DIV64) begin
      last = adcc_pkg::LAST_DIV64;
    end else begin
      valid = 1'b0; // Reserved codes give no clock
    end
  end

  // Compare with >= so a smaller ratio picked mid-count still wraps
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= adcc_pkg::DIV_ZERO;
      tick <= 1'b0;
    end else if (!run || !valid) begin
      count_q <= adcc_pkg::DIV_ZERO;
      tick <= 1'b0;
    end else if (count_q >= last) begin
      count_q <= adcc_pkg::DIV_ZERO;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + adcc_pkg::DIV_ONE;
      tick <= 1'b0;
    end
  end
endmodule

// file: hdl/adcc_sar.sv
// Successive approximation engine, one trial per conversion clock tick.
// Assumes an analog comparator pin that is high when input exceeds the trial.
`timescale 1ns/1ns
module adcc_sar (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  input wire logic start,
  input wire logic comparator_pin,
  output logic busy,
  output logic done,
  output logic hold,
  output logic [adcc_pkg::RES_W-1:0] trial,
  output logic [adcc_pkg::RES_W-1:0] result
);
  adcc_pkg::adcc_sar_state_type state_q;
  logic meta_q;
  logic comp_q;
  logic [adcc_pkg::BIT_W-1:0] bit_q;
  logic [adcc_pkg::RES_W-1:0] mask;
  logic [adcc_pkg::RES_W-1:0] kept;

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      comp_q <= 1'b0;
    end else begin
      meta_q <= comparator_pin;
      comp_q <= meta_q;
    end
  end

  assign mask = adcc_pkg::TRIAL_MSB >> (adcc_pkg::TOP_BIT - bit_q);
  assign kept = comp_q ? trial : (trial & ~mask);

  // ----------------------------------------------------------------
  // Trial sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= adcc_pkg::SAR_IDLE;
      bit_q <= adcc_pkg::TOP_BIT;
      trial <= adcc_pkg::RES_RESET;
      result <= adcc_pkg::RES_RESET;
      busy <= 1'b0;
      done <= 1'b0;
      hold <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        adcc_pkg::SAR_IDLE: begin
          if (start && run) begin
            state_q <= adcc_pkg::SAR_CONVERT;
            bit_q <= adcc_pkg::TOP_BIT;
            trial <= adcc_pkg::TRIAL_MSB;
            busy <= 1'b1;
            hold <= 1'b1;
          end
        end
        adcc_pkg::SAR_CONVERT: begin
          if (!run) begin
            state_q <= adcc_pkg::SAR_IDLE;
            busy <= 1'b0;
            hold <= 1'b0;
          end else if (tick && bit_q == adcc_pkg::BIT_ZERO) begin
            state_q <= adcc_pkg::SAR_IDLE;
            result <= kept;
            busy <= 1'b0;
            done <= 1'b1;
            hold <= 1'b0; // Back to tracking; no discharge step
          end else if (tick) begin
            bit_q <= bit_q - adcc_pkg::BIT_ONE;
            trial <= kept | (mask >> 1);
          end
        end
        default: state_q <= adcc_pkg::SAR_IDLE;
      endcase
    end
  end
endmodule

// file: hdl/adcc_top.sv
// Converter control and result registers behind an Avalon-MM slave.
// Assumes one 20 MHz clock, an analog front end, and a level interrupt sink.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module adcc_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [adcc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [adcc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [adcc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic comparator_high,
  output logic converter_enable,
  output logic reference_select,
  output logic [adcc_pkg::CHS_W-1:0] channel_select,
  output logic sample_hold,
  output logic [adcc_pkg::RES_W-1:0] dac_trial,
  output logic conv_busy
);
  logic request;
  logic accept;
  logic wr_lane;
  logic go_q;
  logic [adcc_pkg::CS_W-1:0] cs_q;
  logic flag_q;
  logic irq_en_q;
  logic start_q;
  logic tick;
  logic sar_done;
  logic [adcc_pkg::RES_W-1:0] conversion_result;
  logic [adcc_pkg::DATA_W-1:0] read_d;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle per access keeps read data registered
  assign request = avs_read || avs_write;
  assign accept = request && !avs_waitrequest;
  assign wr_lane = avs_write && accept && avs_byteenable[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(request && avs_waitrequest);
    end
  end

  always_comb begin
    read_d = adcc_pkg::READ_ZERO;
    if (avs_address == adcc_pkg::OFF_CTRL0) begin
      read_d[adcc_pkg::ENABLE_BIT] = converter_enable;
      read_d[adcc_pkg::GO_BIT] = go_q;
      read_d[adcc_pkg::CHS_LSB +: adcc_pkg::CHS_W] = channel_select;
    end else if (avs_address == adcc_pkg::OFF_CTRL1) begin
      read_d[adcc_pkg::REF_BIT] = reference_select;
      read_d[adcc_pkg::CS_LSB +: adcc_pkg::CS_W] = cs_q;
    end else if (avs_address == adcc_pkg::OFF_RES_HI) begin
      read_d[1:0] = conversion_result[adcc_pkg::RES_W-1:adcc_pkg::HI_LSB];
    end else if (avs_address == adcc_pkg::OFF_RES_LO) begin
      read_d[7:0] = conversion_result[adcc_pkg::HI_LSB-1:0];
    end else if (avs_address == adcc_pkg::OFF_FLAGS) begin
      read_d[adcc_pkg::DONE_FLAG_BIT] = flag_q;
    end else if (avs_address == adcc_pkg::OFF_ENABLES) begin
      read_d[adcc_pkg::DONE_FLAG_BIT] = irq_en_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata <= adcc_pkg::READ_ZERO;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= read_d;
    end
  end

  // ----------------------------------------------------------------
  // Control zero: enable, go, channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      converter_enable <= 1'b0;
      channel_select <= adcc_pkg::CHS_RESET;
    end else if (wr_lane && avs_address == adcc_pkg::OFF_CTRL0) begin
      converter_enable <= avs_writedata[adcc_pkg::ENABLE_BIT];
      channel_select <= avs_writedata[adcc_pkg::CHS_LSB +: adcc_pkg::CHS_W];
    end
  end

  // Go cannot be cleared by software mid-conversion; disable aborts instead
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      go_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      // Go starts only with enable in the same write; start_q rises on the edge that stores the enable bit
      if (wr_lane && avs_address == adcc_pkg::OFF_CTRL0 && !go_q
          && avs_writedata[adcc_pkg::GO_BIT] && avs_writedata[adcc_pkg::ENABLE_BIT]) begin
        go_q <= 1'b1;
        start_q <= 1'b1;
      end else if (!converter_enable || sar_done) begin
        go_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control one: clock select, reference
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_q <= adcc_pkg::CS_RESET;
      reference_select <= 1'b0;
    end else if (wr_lane && avs_address == adcc_pkg::OFF_CTRL1) begin
      cs_q <= avs_writedata[adcc_pkg::CS_LSB +: adcc_pkg::CS_W];
      reference_select <= avs_writedata[adcc_pkg::REF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Done flag, enable and interrupt
  // ----------------------------------------------------------------
  // A completion in the clearing cycle wins over the clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (sar_done) begin
      flag_q <= 1'b1;
    end else if (wr_lane && avs_address == adcc_pkg::OFF_FLAGS
                 && avs_writedata[adcc_pkg::DONE_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_en_q <= 1'b0;
    end else if (wr_lane && avs_address == adcc_pkg::OFF_ENABLES) begin
      irq_en_q <= avs_writedata[adcc_pkg::DONE_FLAG_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= flag_q && irq_en_q;
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock and engine
  // ----------------------------------------------------------------
  adcc_clkdiv u_clkdiv (
    .clock(clock),
    .rst(rst),
    .run(converter_enable),
    .select(cs_q),
    .tick(tick)
  );

  adcc_sar u_sar (
    .clock(clock),
    .rst(rst),
    .run(converter_enable),
    .tick(tick),
    .start(start_q),
    .comparator_pin(comparator_high),
    .busy(conv_busy),
    .done(sar_done),
    .hold(sample_hold),
    .trial(dac_trial),
    .result(conversion_result)
  );

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  logic [adcc_pkg::DIV_W:0] gap_q;
  logic seen_q;
  logic [adcc_pkg::DIV_W-1:0] exp_last;
  logic [adcc_pkg::BIT_W-1:0] ticks_q;

  always_comb begin
    exp_last = adcc_pkg::LAST_DIV8;
    if (cs_q[1:0] == adcc_pkg::CS_RC_LOW) begin
      exp_last = adcc_pkg::LAST_RC;
    end else if (cs_q == adcc_pkg::CS_DIV16) begin
      exp_last = adcc_pkg::LAST_DIV16;
    end else if (cs_q == adcc_pkg::CS_DIV32) begin
      exp_last = adcc_pkg::LAST_DIV32;
    end else if (cs_q == adcc_pkg::CS_DIV64) begin
      exp_last = adcc_pkg::LAST_DIV64;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= tick ? '0 : gap_q + 1'b1;
      if (!converter_enable || (wr_lane && avs_address == adcc_pkg::OFF_CTRL1)) begin
        seen_q <= 1'b0;
      end else if (tick) begin
        seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ticks_q <= '0;
    end else if (start_q) begin
      ticks_q <= '0;
    end else if (conv_busy && tick) begin
      ticks_q <= ticks_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_disable_aborts: assert property (!converter_enable ##1 !converter_enable |-> !conv_busy && !go_q)
    else $error("conversion survives disable");
  a_osc_div_gap: assert property (tick && seen_q && cs_q[1:0] != adcc_pkg::CS_RC_LOW
    |-> gap_q == {1'b0, exp_last})
    else $error("conversion clock ratio wrong");
  a_rc_div_gap: assert property (tick && seen_q && cs_q[1:0] == adcc_pkg::CS_RC_LOW
    |-> gap_q == 7'h0f)
    else $error("rc clock is not divide by sixteen");
  a_ref_follows: assert property (wr_lane && avs_address == adcc_pkg::OFF_CTRL1
    |=> reference_select == $past(avs_writedata[adcc_pkg::REF_BIT]))
    else $error("reference select not written");
  a_ctrl1_zero: assert property (avs_read && avs_waitrequest && avs_address == adcc_pkg::OFF_CTRL1
    |=> avs_readdata[7] == 1'b0 && avs_readdata[3:1] == 3'h0 && avs_readdata[31:8] == 24'h0)
    else $error("unimplemented control bits read nonzero");
  a_hi_read: assert property (avs_read && avs_waitrequest && avs_address == adcc_pkg::OFF_RES_HI
    |=> avs_readdata == {30'h0, $past(conversion_result[9:8])})
    else $error("result high read wrong");
  a_lo_read: assert property (avs_read && avs_waitrequest && avs_address == adcc_pkg::OFF_RES_LO
    |=> avs_readdata == {24'h0, $past(conversion_result[7:0])})
    else $error("result low read wrong");
  a_ten_trials: assert property (sar_done |-> ticks_q == adcc_pkg::TRIALS)
    else $error("conversion did not take ten trials");
  a_hold_release: assert property (sar_done |-> !sample_hold ##1 !sample_hold)
    else $error("hold still closed after completion");
  a_go_held: assert property (start_q |-> go_q until_with (sar_done || !converter_enable))
    else $error("go bit dropped during conversion");
  a_go_clears: assert property (sar_done |=> !go_q)
    else $error("go bit not cleared at completion");
  a_chs_written: assert property (wr_lane && avs_address == adcc_pkg::OFF_CTRL0
    |=> channel_select == $past(avs_writedata[6:2]))
    else $error("channel select not written");
  a_irq_raise: assert property (sar_done && irq_en_q && !avs_write ##1 !avs_write |-> ##1 irq)
    else $error("interrupt missing after completion");
  a_irq_masked: assert property (!irq_en_q ##1 !irq_en_q |-> !irq)
    else $error("interrupt raised while masked");
  a_irq_follows_flag: assert property (!flag_q |=> !irq)
    else $error("interrupt without the done flag");

  // ----------------------------------------------------------------
  // Bus and register assertions
  // ----------------------------------------------------------------
  a_wait_answer: assert property (request && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_rdata_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits nonzero");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > adcc_pkg::OFF_ENABLES
    |=> avs_readdata == adcc_pkg::READ_ZERO)
    else $error("unmapped read nonzero");
  a_ctrl0_read: assert property (avs_read && avs_waitrequest && avs_address == adcc_pkg::OFF_CTRL0
    |=> avs_readdata[7:0] == {1'b0, $past(channel_select), $past(go_q), $past(converter_enable)})
    else $error("control zero read wrong");
  a_ctrl1_read: assert property (avs_read && avs_waitrequest && avs_address == adcc_pkg::OFF_CTRL1
    |=> avs_readdata[6:4] == $past(cs_q) && avs_readdata[0] == $past(reference_select))
    else $error("control one read wrong");
  a_enable_written: assert property (wr_lane && avs_address == adcc_pkg::OFF_CTRL0
    |=> converter_enable == $past(avs_writedata[adcc_pkg::ENABLE_BIT]))
    else $error("enable bit not written");
  a_cs_written: assert property (wr_lane && avs_address == adcc_pkg::OFF_CTRL1
    |=> cs_q == $past(avs_writedata[6:4]))
    else $error("clock select not written");

  // ----------------------------------------------------------------
  // Conversion and flag assertions
  // ----------------------------------------------------------------
  a_idle_no_tick: assert property (!converter_enable ##1 !converter_enable |-> !tick)
    else $error("conversion clock runs while disabled");
  a_busy_abort: assert property (conv_busy && !converter_enable |=> !conv_busy)
    else $error("conversion survives disable");
  a_reserved_stall: assert property (cs_q[1:0] == 2'h0 ##1 cs_q[1:0] == 2'h0 |-> !tick)
    else $error("reserved clock code ticks");
  a_trial_msb: assert property (start_q && converter_enable |=> conv_busy && dac_trial == 10'h200)
    else $error("conversion did not start at top trial");
  a_result_load: assert property ($changed(conversion_result) |-> sar_done)
    else $error("result changed without completion");
  a_go_start: assert property (start_q |-> go_q)
    else $error("start without go bit");
  a_go_ignored: assert property (go_q && wr_lane && avs_address == adcc_pkg::OFF_CTRL0
    |=> !start_q)
    else $error("second start while converting");
  a_flag_set: assert property (sar_done |=> flag_q)
    else $error("done flag not set");
  a_flag_clear: assert property (wr_lane && avs_address == adcc_pkg::OFF_FLAGS
    && avs_writedata[adcc_pkg::DONE_FLAG_BIT] && !sar_done |=> !flag_q)
    else $error("done flag not cleared");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_enable_go: cover property (!converter_enable ##1 start_q);
  c_conversion: cover property (start_q ##[1:800] sar_done);
  c_irq_rise: cover property (sar_done ##2 irq);
  c_abort: cover property (conv_busy ##1 !converter_enable);
  c_rc_clock: cover property (sar_done && cs_q[1:0] == adcc_pkg::CS_RC_LOW);
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the converter control block: registers, conversions, interrupt.
// Assumes the design files under hdl/ and one 50 ns clock; the bench models the comparator.
`timescale 1ns/1ns
module tb_top;
  // ------------------------------------------------------------
  // Signals, design and comparator model
  // ------------------------------------------------------------
  typedef struct {logic [adcc_pkg::ADDR_W-1:0] a; logic [7:0] d; logic [7:0] e;} adcc_reg_row_type;
  typedef struct {logic [2:0] cs; int n; logic [9:0] code; logic rf;} adcc_conv_row_type;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, irq, comparator_high;
  logic converter_enable, reference_select, sample_hold, conv_busy;
  logic [adcc_pkg::ADDR_W-1:0] avs_address;
  logic [adcc_pkg::DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, be_sel;
  logic [adcc_pkg::CHS_W-1:0] channel_select;
  logic [adcc_pkg::RES_W-1:0] dac_trial;
  logic [10:0] vin2;
  int miscompares, n_tests, cycles;
  adcc_reg_row_type rows [8];
  adcc_conv_row_type convs [6];
  adcc_top uut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .comparator_high(comparator_high), .converter_enable(converter_enable),
    .reference_select(reference_select), .channel_select(channel_select), .sample_hold(sample_hold),
    .dac_trial(dac_trial), .conv_busy(conv_busy));
  // Input held at half a step so no trial ever ties with it
  always @(posedge clock) comparator_high <= (vin2 > {dac_trial, 1'b0});
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ------------------------------------------------------------
  // Checking, bus and closing tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [adcc_pkg::ADDR_W-1:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int k;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be_sel;
    avs_write <= w;
    avs_read <= ~w;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check(32'(k < 20), 32'h1, "bus answer");
  endtask
  task automatic wr(input logic [adcc_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [adcc_pkg::ADDR_W-1:0] a, input logic [7:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, e}, what);
  endtask
  // Channel 6, go and enable; duration bounds follow from ten ticks of period n
  task automatic convert(input adcc_conv_row_type r);
    int k;
    int t0;
    vin2 = {r.code, 1'b1};
    wr(adcc_pkg::OFF_CTRL1, {1'b0, r.cs, 3'h0, r.rf});
    wr(adcc_pkg::OFF_CTRL0, 8'h19);
    repeat (100) @(posedge clock); // Acquisition wait of 5 us before go
    wr(adcc_pkg::OFF_CTRL0, 8'h1b);
    k = 0;
    while (conv_busy !== 1'b1 && k < 10) begin
      @(posedge clock);
      k++;
    end
    t0 = cycles;
    check({converter_enable, reference_select, channel_select, sample_hold}, {1'b1, r.rf, 5'h06, 1'b1}, "pins");
    rdc(adcc_pkg::OFF_CTRL0, 8'h1b, "go held");
    while (conv_busy === 1'b1 && cycles - t0 < 2000) @(posedge clock);
    check(32'(cycles - t0 >= 9 * r.n && cycles - t0 <= 10 * r.n + 2), 32'h1, "conversion time");
    rdc(adcc_pkg::OFF_CTRL0, 8'h19, "go cleared");
    rdc(adcc_pkg::OFF_RES_HI, {6'h0, r.code[9:8]}, "result high");
    rdc(adcc_pkg::OFF_RES_LO, r.code[7:0], "result low");
    rdc(adcc_pkg::OFF_FLAGS, 8'h40, "done flag");
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rows = '{'{adcc_pkg::OFF_CTRL1, 8'hff, 8'h71}, '{adcc_pkg::OFF_CTRL1, 8'h00, 8'h00},
      '{adcc_pkg::OFF_CTRL0, 8'h7c, 8'h7c}, '{adcc_pkg::OFF_RES_HI, 8'hff, 8'h00},
      '{adcc_pkg::OFF_RES_LO, 8'hff, 8'h00}, '{adcc_pkg::OFF_ENABLES, 8'h40, 8'h40},
      '{adcc_pkg::OFF_ENABLES, 8'h00, 8'h00}, '{5'h18, 8'hff, 8'h00}};
    // First code leans on a trial of zero before start, the rest sit above every trial
    convs = '{'{3'h1, 8, 10'h2a5, 1'b0}, '{3'h5, 16, 10'h3ff, 1'b1}, '{3'h2, 32, 10'h3ff, 1'b0},
      '{3'h6, 64, 10'h3ff, 1'b1}, '{3'h3, 16, 10'h3ff, 1'b0}, '{3'h7, 16, 10'h3ff, 1'b1}};
    rst = 1'b1;
    {avs_read, avs_write, comparator_high} = 3'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    be_sel = 4'h1;
    avs_byteenable = 4'h1;
    vin2 = 11'h000;
    cycles = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check({irq, converter_enable, conv_busy, sample_hold, avs_waitrequest}, 5'h01, "reset pins");
    rdc(adcc_pkg::OFF_CTRL1, 8'h00, "ctrl1 reset");
    rdc(adcc_pkg::OFF_FLAGS, 8'h00, "flag reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e, "register row");
    end
    check(channel_select, 5'h1f, "channel pins");
    foreach (convs[i]) begin
      convert(convs[i]);
      if (i < 5) wr(adcc_pkg::OFF_FLAGS, 8'h40);
    end
    // Interrupt: flag still set from the last conversion
    check(irq, 1'b0, "irq masked");
    wr(adcc_pkg::OFF_ENABLES, 8'h40);
    repeat (2) @(posedge clock);
    check(irq, 1'b1, "irq raised");
    wr(adcc_pkg::OFF_FLAGS, 8'h40);
    repeat (2) @(posedge clock);
    check(irq, 1'b0, "irq cleared");
    rdc(adcc_pkg::OFF_FLAGS, 8'h00, "flag cleared");
    convert(convs[1]);
    check(irq, 1'b1, "irq after conversion");
    wr(adcc_pkg::OFF_ENABLES, 8'h00);
    wr(adcc_pkg::OFF_FLAGS, 8'h40);
    // Reserved clock codes give no ticks; disabling aborts the stalled conversion
    for (int c = 0; c < 8; c += 4) begin
      wr(adcc_pkg::OFF_CTRL1, {1'b0, 3'(c), 4'h0});
      wr(adcc_pkg::OFF_CTRL0, 8'h1b);
      repeat (200) @(posedge clock);
      check(conv_busy, 1'b1, "reserved stall");
      wr(adcc_pkg::OFF_CTRL0, 8'h18);
      repeat (2) @(posedge clock);
      check({conv_busy, converter_enable, irq}, 3'h0, "disable abort");
      rdc(adcc_pkg::OFF_CTRL0, 8'h18, "go after abort");
      rdc(adcc_pkg::OFF_RES_LO, 8'hff, "result kept");
    end
    // Lane zero off: write answered but ignored
    be_sel = 4'h0;
    wr(adcc_pkg::OFF_CTRL1, 8'h71);
    be_sel = 4'h1;
    rdc(adcc_pkg::OFF_CTRL1, 8'h40, "masked write");
    // Reset in mid-conversion; enable and go arrive in one write
    wr(adcc_pkg::OFF_CTRL1, 8'h60);
    wr(adcc_pkg::OFF_CTRL0, 8'h1b);
    repeat (20) @(posedge clock);
    check(conv_busy, 1'b1, "busy before reset");
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check({irq, converter_enable, conv_busy, sample_hold, dac_trial, avs_waitrequest}, 15'h0001, "mid reset");
    rdc(adcc_pkg::OFF_CTRL0, 8'h00, "ctrl0 after reset");
    rdc(adcc_pkg::OFF_CTRL1, 8'h00, "ctrl1 after reset");
    final_report();
  end
endmodule
